// ---- src/iirop_pkg.sv ----
package iirop_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_ENABLE   = 8'h00;
   localparam logic [7:0] OFF_BOARD_SWITCH_IDENTIFIER  = 8'h07;
   localparam logic [7:0] OFF_IO_LOW   = 8'hC0;
   localparam logic [7:0] OFF_IO_HIGH  = 8'hC4;
   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int         ENABLE_BIT   = 0;
   localparam int         ID_LSB       = 2;
   localparam int         ID_WIDTH     = 4;
   localparam int         ADDR_WIDTH   = 8;
   localparam int         DATA_WIDTH   = 8;
   localparam logic       ENABLE_RESET = 1'b0;
   localparam logic [7:0] OUT_RESET    = 8'h00;
   localparam logic [7:0] UNDEF_READ   = 8'hFF;
endpackage

// ---- src/iirop_out_reg.sv ----
`timescale 1ns/1ns
module iirop_out_reg #(
   parameter int WIDTH = 8
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_sync_n,
   input  wire logic             load,
   input  wire logic             clear,
   input  wire logic [WIDTH-1:0] load_data,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] next_q;

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("Register width must be at least 1");
      end
   endgenerate

   always_comb begin
      next_q = q;
      if (clear) begin
         next_q = '0;
      end else if (load) begin
         next_q = load_data;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
endmodule

// ---- src/iirop_top.sv ----
// Summary of operation
// - Enable bit resets low; while low all input and output operations are disabled.
// - Enable is bit 0 of write-only offset 0; 1 enables, 0 disables.
// - Offset 7 read returns card identifier in bits 5 to 2.
// - Identifier follows the four-position board switch, independent of slot.
// - Identifier bits read back inverted; software shifts, inverts, masks.
// - Reads at C0 and C4 return input channels 0-7 and 8-15.
// - Writes at C0 and C4 load relay channels 0-7 and 8-15.
// - Output bit 1 energizes relay to normally-open; 0 rests normally-closed.
// - Power-on, hardware or software reset clears output registers to zero.
// - Input read shows current input channel state at read time.
`timescale 1ns/1ns
module iirop_top (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] bus_addr,
   input  wire logic       bus_rd,
   input  wire logic       bus_wr,
   input  wire logic [7:0] bus_wdata,
   output logic      [7:0] bus_rdata,
   input  wire logic [3:0] identifier_dip_switch,
   input  wire logic [7:0] isolated_inputs_low,
   input  wire logic [7:0] isolated_inputs_high,
   output logic      [7:0] relay_outputs_low,
   output logic      [7:0] relay_outputs_high,
   output logic            channel_enable
);
   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   generate
      if (iirop_pkg::DATA_WIDTH != 8 || iirop_pkg::ADDR_WIDTH != 8) begin : g_bad_width
         $error("Bus and register width must be 8 bits");
      end
   endgenerate

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic [1:0] rst_pipe;
   logic       rst_sync_n;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_sync_n = rst_pipe[1];

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   logic wr_enable;
   logic wr_low;
   logic wr_high;
   logic disable_now;

   assign wr_enable   = bus_wr && hit(bus_addr, iirop_pkg::OFF_ENABLE);
   assign wr_low      = bus_wr && channel_enable && hit(bus_addr, iirop_pkg::OFF_IO_LOW);
   assign wr_high     = bus_wr && channel_enable && hit(bus_addr, iirop_pkg::OFF_IO_HIGH);
   assign disable_now = wr_enable && !bus_wdata[iirop_pkg::ENABLE_BIT];

   // ----------------------------------------
   // Enable register
   // ----------------------------------------
   logic next_channel_enable;

   always_comb begin
      next_channel_enable = channel_enable;
      if (wr_enable) begin
         next_channel_enable = bus_wdata[iirop_pkg::ENABLE_BIT];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         channel_enable <= iirop_pkg::ENABLE_RESET;
      end else begin
         channel_enable <= next_channel_enable;
      end
   end

   // ----------------------------------------
   // Relay output registers
   // ----------------------------------------
   // Software disable clears relays to normally-closed
   iirop_out_reg #(.WIDTH(iirop_pkg::DATA_WIDTH)) u_out_low (
      .sys_clk    (sys_clk),
      .rst_sync_n (rst_sync_n),
      .load       (wr_low),
      .clear      (disable_now),
      .load_data  (bus_wdata),
      .q          (relay_outputs_low)
   );

   iirop_out_reg #(.WIDTH(iirop_pkg::DATA_WIDTH)) u_out_high (
      .sys_clk    (sys_clk),
      .rst_sync_n (rst_sync_n),
      .load       (wr_high),
      .clear      (disable_now),
      .load_data  (bus_wdata),
      .q          (relay_outputs_high)
   );

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = bus_rdata;
      if (bus_rd) begin
         next_rdata = iirop_pkg::UNDEF_READ;
         if (hit(bus_addr, iirop_pkg::OFF_BOARD_SWITCH_IDENTIFIER)) begin
            next_rdata = {2'h3, ~identifier_dip_switch, 2'h3};
         end else if (hit(bus_addr, iirop_pkg::OFF_IO_LOW)) begin
            next_rdata = channel_enable ? isolated_inputs_low : 8'h00;
         end else if (hit(bus_addr, iirop_pkg::OFF_IO_HIGH)) begin
            next_rdata = channel_enable ? isolated_inputs_high : 8'h00;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         bus_rdata <= 8'h00;
      end else begin
         bus_rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   enable_low_out_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      !channel_enable |=> ($stable(relay_outputs_low) || relay_outputs_low == 8'h00))
      else $error("relay low changed while disabled");
   enable_write_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      wr_enable |=> channel_enable == $past(bus_wdata[0]))
      else $error("enable bit not taken");
   board_switch_identifier_read_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bus_rd && bus_addr == 8'h07 |=> bus_rdata[5:2] == ~$past(identifier_dip_switch))
      else $error("board_switch_identifier wrong");
   input_read_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bus_rd && channel_enable && bus_addr == 8'hC4 |=> bus_rdata == $past(isolated_inputs_high))
      else $error("input high read wrong");
   out_load_low_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bus_wr && channel_enable && bus_addr == 8'hC0 |=> relay_outputs_low == $past(bus_wdata))
      else $error("relay low not loaded");
   out_load_high_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bus_wr && channel_enable && bus_addr == 8'hC4 |=> relay_outputs_high == $past(bus_wdata))
      else $error("relay high not loaded");
   sw_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bus_wr && bus_addr == 8'h00 && !bus_wdata[0] |=> relay_outputs_low == 8'h00 && relay_outputs_high == 8'h00)
      else $error("relays not cleared");
   id_write_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bus_wr && bus_addr == 8'h07 |=> $stable(channel_enable) && $stable(relay_outputs_high))
      else $error("id write had effect");

   // ----------------------------------------
   // Read, reset, refusal and hold checks
   // ----------------------------------------
   input_low_read_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bus_rd && channel_enable && bus_addr == iirop_pkg::OFF_IO_LOW |=> bus_rdata == $past(isolated_inputs_low))
      else $error("input low read wrong");

   off_read_low_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bus_rd && !channel_enable && bus_addr == iirop_pkg::OFF_IO_LOW |=> bus_rdata == 8'h00)
      else $error("disabled low read not zero");

   off_read_high_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bus_rd && !channel_enable && bus_addr == iirop_pkg::OFF_IO_HIGH |=> bus_rdata == 8'h00)
      else $error("disabled high read not zero");

   off_write_low_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bus_wr && !channel_enable && bus_addr == iirop_pkg::OFF_IO_LOW |=> $stable(relay_outputs_low))
      else $error("disabled low write took effect");

   off_write_high_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bus_wr && !channel_enable && bus_addr == iirop_pkg::OFF_IO_HIGH |=> $stable(relay_outputs_high))
      else $error("disabled high write took effect");

   reset_clear_a: assert property (@(posedge sys_clk)
      !rst_sync_n |-> relay_outputs_low == 8'h00 && relay_outputs_high == 8'h00 && !channel_enable)
      else $error("outputs not clear in reset");

   enable_read_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bus_rd && bus_addr == iirop_pkg::OFF_ENABLE |=> bus_rdata == iirop_pkg::UNDEF_READ)
      else $error("enable offset read wrong");

   id_reserved_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bus_rd && bus_addr == iirop_pkg::OFF_BOARD_SWITCH_IDENTIFIER |=> bus_rdata[7:6] == 2'h3 && bus_rdata[1:0] == 2'h3)
      else $error("id reserved bits wrong");

   rdata_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      !bus_rd |=> $stable(bus_rdata))
      else $error("read data changed without read");

   relay_hold_low_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      !bus_wr |=> $stable(relay_outputs_low))
      else $error("relay low changed without write");

   relay_hold_high_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      !bus_wr |=> $stable(relay_outputs_high))
      else $error("relay high changed without write");

   id_write_low_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bus_wr && bus_addr == iirop_pkg::OFF_BOARD_SWITCH_IDENTIFIER |=> $stable(relay_outputs_low))
      else $error("id write changed relay low");

   enable_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      !(bus_wr && bus_addr == iirop_pkg::OFF_ENABLE) |=> $stable(channel_enable))
      else $error("enable changed without write");

   enable_set_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bus_wr && bus_addr == iirop_pkg::OFF_ENABLE && bus_wdata[0] |=> $stable(relay_outputs_low))
      else $error("enabling changed relays");

   unmapped_read_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      bus_rd && bus_addr != iirop_pkg::OFF_BOARD_SWITCH_IDENTIFIER && bus_addr != iirop_pkg::OFF_IO_LOW
      && bus_addr != iirop_pkg::OFF_IO_HIGH |=> bus_rdata == iirop_pkg::UNDEF_READ)
      else $error("unmapped read wrong");
endmodule

// ---- bench/iirop_host.sv ----
`timescale 1ns/1ns
module iirop_host (
   input  wire logic       sys_clk,
   output logic      [7:0] bus_addr,
   output logic            bus_rd,
   output logic            bus_wr,
   output logic      [7:0] bus_wdata
);
   initial begin
      bus_addr  = 8'h00;
      bus_rd    = 1'b0;
      bus_wr    = 1'b0;
      bus_wdata = 8'h00;
   end
   // One strobed cycle, then bus lines flipped so stale data never looks valid
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= wr;
      bus_rd    <= !wr;
      @(posedge sys_clk);
      bus_wr    <= 1'b0;
      bus_rd    <= 1'b0;
      bus_addr  <= ~a;
      bus_wdata <= ~d;
      #1;
   endtask
endmodule

// ---- bench/test_isolated_input_relay_output_port.sv ----
`timescale 1ns/1ns
module test_isolated_input_relay_output_port;
   logic        sys_clk = 1'b0;
   logic        rst_n;
   logic [3:0]  sw;
   logic [7:0]  in_lo, in_hi, bus_addr, bus_wdata, bus_rdata, rl, rh;
   logic        bus_rd, bus_wr, en;
   logic        rd_seen = 1'b0;
   logic [31:0] r;
   logic [7:0]  exp_q[$];
   int          errors = 0;
   int          cmp_count = 0;
   always #50 sys_clk = ~sys_clk;
   iirop_host u_host (.sys_clk(sys_clk), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
                      .bus_wdata(bus_wdata));
   iirop_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_rd(bus_rd),
                    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
                    .identifier_dip_switch(sw), .isolated_inputs_low(in_lo), .isolated_inputs_high(in_hi),
                    .relay_outputs_low(rl), .relay_outputs_high(rh), .channel_enable(en));
   // ----------------------------------------
   // Checking
   // ----------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_host.access(1'b0, a, 8'h00);
   endtask
   always @(posedge sys_clk) rd_seen <= bus_rd;
   always @(negedge sys_clk) if (rd_seen === 1'b1 && exp_q.size() > 0) check(bus_rdata, exp_q.pop_front());
   task automatic final_report;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   initial begin
      rst_n = 1'b0;
      sw    = 4'h0;
      in_lo = 8'h00;
      in_hi = 8'h5A;
      r     = $urandom(32'hB0643F8E);
      do_reset();
      check(rl, 8'h00);
      check({7'h00, en}, 8'h00);
      rd(iirop_pkg::OFF_IO_HIGH, 8'h00);
      u_host.access(1'b1, iirop_pkg::OFF_IO_HIGH, 8'h3C);
      check(rh, 8'h00);
      u_host.access(1'b1, iirop_pkg::OFF_ENABLE, 8'h01);
      check({7'h00, en}, 8'h01);
      for (int i = 0; i < 16; i++) begin
         @(posedge sys_clk) sw <= i[3:0];
         rd(iirop_pkg::OFF_BOARD_SWITCH_IDENTIFIER, {2'h3, ~i[3:0], 2'h3});
      end
      for (int i = 0; i < 8; i++) begin
         r = $urandom;
         @(posedge sys_clk) in_lo <= r[7:0];
         in_hi <= r[15:8];
         rd(iirop_pkg::OFF_IO_LOW, r[7:0]);
         rd(iirop_pkg::OFF_IO_HIGH, r[15:8]);
         u_host.access(1'b1, iirop_pkg::OFF_IO_LOW, r[23:16]);
         u_host.access(1'b1, iirop_pkg::OFF_IO_HIGH, r[31:24]);
         check(rl, r[23:16]);
         check(rh, r[31:24]);
         rd(iirop_pkg::OFF_IO_LOW, r[7:0]);
      end
      u_host.access(1'b1, iirop_pkg::OFF_BOARD_SWITCH_IDENTIFIER, 8'h00);
      check(rl, r[23:16]);
      rd(iirop_pkg::OFF_BOARD_SWITCH_IDENTIFIER, 8'hC3);
      rd(iirop_pkg::OFF_ENABLE, iirop_pkg::UNDEF_READ);
      rd(8'h55, iirop_pkg::UNDEF_READ);
      u_host.access(1'b1, iirop_pkg::OFF_ENABLE, 8'h00);
      check({7'h00, en}, 8'h00);
      check(rh, 8'h00);
      rd(iirop_pkg::OFF_IO_LOW, 8'h00);
      u_host.access(1'b1, iirop_pkg::OFF_ENABLE, 8'h01);
      u_host.access(1'b1, iirop_pkg::OFF_IO_LOW, 8'hFF);
      check(rl, 8'hFF);
      do_reset();
      check(rl, 8'h00);
      check({7'h00, en}, 8'h00);
      final_report();
   end
   initial begin
      #(2000 * 100);
      errors++;
      final_report();
   end
endmodule
